/* shunt_adc_a_map.svh */
`ifndef SHUNT_ADC_A_MAP_SVH
`define SHUNT_ADC_A_MAP_SVH

// --------------------------------------------------------------------------
// Register offsets, reset values and writable masks
// --------------------------------------------------------------------------
`define SAC_TIMING_OFFSET 8'h82
`define SAC_INPUT_OFFSET 8'h83
`define SAC_TIMING_RESET 16'h0400
`define SAC_INPUT_RESET 16'h8010
`define SAC_TIMING_MASK 16'h0f0f
`define SAC_INPUT_MASK 16'h8f3f

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define SAC_SINGLE_SHOT_BIT 11
`define SAC_OSR_LSB 8
`define SAC_GC_EN_BIT 3
`define SAC_GC_DELAY_LSB 0
`define SAC_EN_BIT 15
`define SAC_GAIN_LSB 10
`define SAC_ROUTE_LSB 8
`define SAC_SRC_ROUTE_BIT 5
`define SAC_SINK_ROUTE_BIT 4
`define SAC_SRC_LEVEL_LSB 2
`define SAC_SINK_LEVEL_LSB 0

// --------------------------------------------------------------------------
// Ratio and gain constants
// --------------------------------------------------------------------------
`define SAC_OSR_MIN 14'h0040
`define SAC_OSR_RESET_CODE 3'h4
`define SAC_GAIN_FIRST_DIGITAL 2'h2

`endif

/* shunt_adc_a_pkg.sv */
package shunt_adc_a_pkg;

	typedef enum logic [1:0] {
		route_normal = 2'h0,
		route_reversed = 2'h1,
		route_grounded = 2'h2,
		route_test_dac = 2'h3
	} input_route_e;

	typedef enum logic [1:0] {
		level_off = 2'h0,
		level_4ua = 2'h1,
		level_40ua = 2'h2,
		level_240ua = 2'h3
	} openwire_level_e;

	typedef enum logic [1:0] {
		conv_idle = 2'h0,
		conv_run = 2'h1,
		conv_done = 2'h3
	} conv_state_e;

	typedef struct packed {
		logic single_shot_select;
		logic [2:0] oversample_ratio_code;
		logic global_chop_enable;
		logic [2:0] global_chop_delay;
	} timing_cfg_s;

	typedef struct packed {
		logic channel_enable;
		logic [1:0] gain_code;
		input_route_e input_route_code;
		logic openwire_source_route;
		logic openwire_sink_route;
		openwire_level_e openwire_source_level;
		openwire_level_e openwire_sink_level;
	} input_cfg_s;

	typedef struct packed {
		logic analog_gain_x8;
		logic [1:0] digital_shift;
		logic pos_to_ainp;
		logic neg_to_ainp;
		logic ground_short;
		logic test_dac_select;
		logic source_on_pos;
		logic source_on_neg;
		logic sink_on_pos;
		logic sink_on_neg;
		openwire_level_e source_level;
		openwire_level_e sink_level;
	} analog_ctrl_s;

endpackage : shunt_adc_a_pkg

/* decimation_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shunt_adc_a_map.svh"

module decimation_timer (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	input wire logic mod_tick,
	input wire logic [13:0] ratio,
	output logic data_rate_strobe
);

	logic [13:0] count;
	logic [13:0] next_count;
	logic next_strobe;

	// One strobe per ratio modulator ticks, so the output rate is the
	// modulator clock divided by the ratio. Stopping clears the phase.
	always_comb begin
		next_count = count;
		next_strobe = 1'b0;
		if (!run) begin
			next_count = 14'h0000;
		end else if (mod_tick) begin
			if (count >= ratio - 14'h0001) begin // R02
				next_count = 14'h0000;
				next_strobe = 1'b1;
			end else begin
				next_count = count + 14'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 14'h0000;
			data_rate_strobe <= 1'b0;
		end else if (ce) begin
			count <= next_count;
			data_rate_strobe <= next_strobe;
		end
	end

endmodule : decimation_timer

`default_nettype wire

/* shunt_adc_a_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shunt_adc_a_map.svh"

// Notes on behaviour
// R01: Mode bit 0 converts continuously; 1 converts once per start request.
// R02: Ratio code 0..7 selects 64..8192; data rate is modulator clock over ratio.
// R03: Ratio code resets to 100, a ratio of 1024.
// R04: Timing bit 3 set enables global chop, cleared disables it.
// R05: Disable, standby or power-down zero the result and the two-bit counter.
// R06: Gain codes give 4, 8, 16, 32; 16 and 32 are digital on analog 8.
// R07: Route codes: normal, reversed, grounded with pins open, test DAC.
// R08: Input bit 5 steers the open-wire source to positive or negative pin.
// R09: Input bit 4 steers the open-wire sink; reset picks the negative pin.
// R10: Source level code selects off, 4, 40 or 240 microamps.
// R11: Sink level code selects off, 4, 40 or 240 microamps.
// R12: Reserved bits ignore writes and read zero; chop delay reads back as written.
module shunt_adc_a_config (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic standby,
	input wire logic power_down,
	input wire logic start_request,
	input wire logic mod_tick,
	input wire logic conv_valid,
	input wire logic [23:0] conv_data,
	output shunt_adc_a_pkg::timing_cfg_s timing_cfg,
	output shunt_adc_a_pkg::input_cfg_s input_cfg,
	output shunt_adc_a_pkg::analog_ctrl_s analog_ctrl,
	output logic [13:0] oversample_ratio,
	output logic modulator_run,
	output logic data_rate_strobe,
	output logic [23:0] conv_result,
	output logic [1:0] conversion_counter
);

	// ----------------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------------
	logic [15:0] timing_reg;
	logic [15:0] input_reg;
	logic [15:0] next_timing_reg;
	logic [15:0] next_input_reg;
	logic [15:0] next_rdata;

	always_comb begin
		next_timing_reg = timing_reg;
		next_input_reg = input_reg;
		if (reg_wr && reg_addr == `SAC_TIMING_OFFSET) begin
			next_timing_reg = reg_wdata & `SAC_TIMING_MASK; // R12
		end
		if (reg_wr && reg_addr == `SAC_INPUT_OFFSET) begin
			next_input_reg = reg_wdata & `SAC_INPUT_MASK; // R12
		end
		next_rdata = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				`SAC_TIMING_OFFSET: next_rdata = timing_reg;
				`SAC_INPUT_OFFSET: next_rdata = input_reg;
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			timing_reg <= `SAC_TIMING_RESET; // R03
			input_reg <= `SAC_INPUT_RESET; // R09
			reg_rdata <= 16'h0000;
		end else if (ce) begin
			timing_reg <= next_timing_reg;
			input_reg <= next_input_reg;
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------------
	always_comb begin
		timing_cfg.single_shot_select = timing_reg[`SAC_SINGLE_SHOT_BIT];
		timing_cfg.oversample_ratio_code = timing_reg[`SAC_OSR_LSB +: 3];
		timing_cfg.global_chop_enable = timing_reg[`SAC_GC_EN_BIT]; // R04
		timing_cfg.global_chop_delay = timing_reg[`SAC_GC_DELAY_LSB +: 3]; // R12
		input_cfg.channel_enable = input_reg[`SAC_EN_BIT];
		input_cfg.gain_code = input_reg[`SAC_GAIN_LSB +: 2];
		input_cfg.input_route_code =
			shunt_adc_a_pkg::input_route_e'(input_reg[`SAC_ROUTE_LSB +: 2]);
		input_cfg.openwire_source_route = input_reg[`SAC_SRC_ROUTE_BIT];
		input_cfg.openwire_sink_route = input_reg[`SAC_SINK_ROUTE_BIT];
		input_cfg.openwire_source_level =
			shunt_adc_a_pkg::openwire_level_e'(input_reg[`SAC_SRC_LEVEL_LSB +: 2]);
		input_cfg.openwire_sink_level =
			shunt_adc_a_pkg::openwire_level_e'(input_reg[`SAC_SINK_LEVEL_LSB +: 2]);
	end

	// Ratio doubles per code step from the smallest ratio.
	assign oversample_ratio = `SAC_OSR_MIN << timing_cfg.oversample_ratio_code; // R02

	// ----------------------------------------------------------------------
	// Analog control decode
	// ----------------------------------------------------------------------
	shunt_adc_a_pkg::analog_ctrl_s next_analog_ctrl;

	always_comb begin
		next_analog_ctrl = '0;
		// The analog stage stops at 8; higher gains shift the digital result.
		if (input_cfg.gain_code >= `SAC_GAIN_FIRST_DIGITAL) begin
			next_analog_ctrl.analog_gain_x8 = 1'b1; // R06
			next_analog_ctrl.digital_shift = input_cfg.gain_code - 2'h1; // R06
		end else begin
			next_analog_ctrl.analog_gain_x8 = input_cfg.gain_code[0]; // R06
			next_analog_ctrl.digital_shift = 2'h0;
		end
		case (input_cfg.input_route_code)
			shunt_adc_a_pkg::route_normal: next_analog_ctrl.pos_to_ainp = 1'b1; // R07
			shunt_adc_a_pkg::route_reversed: next_analog_ctrl.neg_to_ainp = 1'b1; // R07
			shunt_adc_a_pkg::route_grounded: next_analog_ctrl.ground_short = 1'b1; // R07
			shunt_adc_a_pkg::route_test_dac: next_analog_ctrl.test_dac_select = 1'b1; // R07
			default: next_analog_ctrl.ground_short = 1'b1;
		endcase
		if (input_cfg.openwire_source_level != shunt_adc_a_pkg::level_off) begin // R10
			next_analog_ctrl.source_on_neg = input_cfg.openwire_source_route; // R08
			next_analog_ctrl.source_on_pos = !input_cfg.openwire_source_route; // R08
		end
		if (input_cfg.openwire_sink_level != shunt_adc_a_pkg::level_off) begin // R11
			next_analog_ctrl.sink_on_neg = input_cfg.openwire_sink_route; // R09
			next_analog_ctrl.sink_on_pos = !input_cfg.openwire_sink_route; // R09
		end
		next_analog_ctrl.source_level = input_cfg.openwire_source_level; // R10
		next_analog_ctrl.sink_level = input_cfg.openwire_sink_level; // R11
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			analog_ctrl <= '0;
		end else if (ce) begin
			analog_ctrl <= next_analog_ctrl;
		end
	end

	// ----------------------------------------------------------------------
	// Conversion sequencing
	// ----------------------------------------------------------------------
	shunt_adc_a_pkg::conv_state_e conv_state;
	shunt_adc_a_pkg::conv_state_e next_conv_state;
	logic active;
	logic [23:0] next_conv_result;
	logic [1:0] next_conversion_counter;

	assign active = input_cfg.channel_enable && !standby && !power_down;
	assign modulator_run = conv_state == shunt_adc_a_pkg::conv_run;

	always_comb begin
		next_conv_state = conv_state;
		if (!active) begin
			next_conv_state = shunt_adc_a_pkg::conv_idle;
		end else if (!timing_cfg.single_shot_select) begin
			next_conv_state = shunt_adc_a_pkg::conv_run; // R01
		end else begin
			case (conv_state)
				shunt_adc_a_pkg::conv_idle: begin
					if (start_request) begin
						next_conv_state = shunt_adc_a_pkg::conv_run;
					end
				end
				shunt_adc_a_pkg::conv_run: begin
					if (conv_valid) begin
						next_conv_state = shunt_adc_a_pkg::conv_done; // R01
					end
				end
				shunt_adc_a_pkg::conv_done: begin
					if (start_request) begin
						next_conv_state = shunt_adc_a_pkg::conv_run;
					end
				end
				default: next_conv_state = shunt_adc_a_pkg::conv_idle;
			endcase
		end
	end

	// A result that lands in the cycle the channel goes inactive is dropped,
	// since clearing must win for the result to read zero afterwards.
	always_comb begin
		next_conv_result = conv_result;
		next_conversion_counter = conversion_counter;
		if (!active) begin
			next_conv_result = 24'h000000; // R05
			next_conversion_counter = 2'h0; // R05
		end else if (conv_valid && modulator_run) begin
			next_conv_result = conv_data;
			next_conversion_counter = conversion_counter + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			conv_state <= shunt_adc_a_pkg::conv_idle;
			conv_result <= 24'h000000;
			conversion_counter <= 2'h0;
		end else if (ce) begin
			conv_state <= next_conv_state;
			conv_result <= next_conv_result;
			conversion_counter <= next_conversion_counter;
		end
	end

	decimation_timer u_timer (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.run(modulator_run),
		.mod_tick(mod_tick),
		.ratio(oversample_ratio),
		.data_rate_strobe(data_rate_strobe)
	);

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_reset_ratio;
		@(posedge clk) disable iff (1'b0)
		rst |=> timing_cfg.oversample_ratio_code == `SAC_OSR_RESET_CODE
			&& oversample_ratio == 14'h0400;
	endproperty
	a_reset_ratio: assert property (p_reset_ratio) else $error("Ratio not 1024 after reset."); // R03

	property p_ratio_value;
		oversample_ratio == (14'h0040 << timing_cfg.oversample_ratio_code);
	endproperty
	a_ratio_value: assert property (p_ratio_value) else $error("Ratio decode wrong."); // R02

	property p_chop_write;
		ce && reg_wr && reg_addr == `SAC_TIMING_OFFSET
			|=> timing_cfg.global_chop_enable == $past(reg_wdata[3]);
	endproperty
	a_chop_write: assert property (p_chop_write) else $error("Chop enable not written."); // R04

	property p_clear;
		ce && (!input_cfg.channel_enable || standby || power_down)
			|=> conv_result == 24'h000000 && conversion_counter == 2'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("Result not cleared."); // R05

	property p_continuous;
		ce && active && !timing_cfg.single_shot_select |=> modulator_run;
	endproperty
	a_continuous: assert property (p_continuous) else $error("Continuous mode stalled."); // R01

	property p_single_stop;
		ce && active && timing_cfg.single_shot_select && modulator_run && conv_valid
			|=> !modulator_run;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("Single shot ran on."); // R01

	property p_gain_digital;
		ce && input_cfg.gain_code == 2'h3
			|=> analog_ctrl.analog_gain_x8 && analog_ctrl.digital_shift == 2'h2;
	endproperty
	a_gain_digital: assert property (p_gain_digital) else $error("Gain 32 decode wrong."); // R06

	property p_ground_route;
		ce && input_cfg.input_route_code == shunt_adc_a_pkg::route_grounded
			|=> analog_ctrl.ground_short && !analog_ctrl.pos_to_ainp && !analog_ctrl.neg_to_ainp;
	endproperty
	a_ground_route: assert property (p_ground_route) else $error("Ground route wrong."); // R07

	property p_source_neg;
		ce && input_cfg.openwire_source_level != shunt_adc_a_pkg::level_off
			&& input_cfg.openwire_source_route
			|=> analog_ctrl.source_on_neg && !analog_ctrl.source_on_pos;
	endproperty
	a_source_neg: assert property (p_source_neg) else $error("Source route wrong."); // R08

	property p_sink_route;
		ce && input_cfg.openwire_sink_level != shunt_adc_a_pkg::level_off
			|=> analog_ctrl.sink_on_neg == $past(input_cfg.openwire_sink_route);
	endproperty
	a_sink_route: assert property (p_sink_route) else $error("Sink route wrong."); // R09

	property p_source_off;
		ce && input_cfg.openwire_source_level == shunt_adc_a_pkg::level_off
			|=> !analog_ctrl.source_on_pos && !analog_ctrl.source_on_neg;
	endproperty
	a_source_off: assert property (p_source_off) else $error("Source not off."); // R10

	property p_sink_off;
		ce && input_cfg.openwire_sink_level == shunt_adc_a_pkg::level_off
			|=> !analog_ctrl.sink_on_pos && !analog_ctrl.sink_on_neg;
	endproperty
	a_sink_off: assert property (p_sink_off) else $error("Sink not off."); // R11

	property p_reserved;
		ce && reg_rd |=> (reg_rdata & ~(($past(reg_addr) == `SAC_INPUT_OFFSET) ?
			`SAC_INPUT_MASK : `SAC_TIMING_MASK)) == 16'h0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved bits read nonzero."); // R12

endmodule : shunt_adc_a_config

`default_nettype wire

/* shunt_adc_a_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "shunt_adc_a_map.svh"

module shunt_adc_a_config_tb;
	// ----------------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic standby = 1'b0;
	logic power_down = 1'b0;
	logic start_request = 1'b0;
	logic mod_tick = 1'b0;
	logic conv_valid = 1'b0;
	logic [23:0] conv_data = 24'h000000;
	shunt_adc_a_pkg::timing_cfg_s timing_cfg;
	shunt_adc_a_pkg::input_cfg_s input_cfg;
	shunt_adc_a_pkg::analog_ctrl_s analog_ctrl;
	logic [13:0] oversample_ratio;
	logic modulator_run;
	logic data_rate_strobe;
	logic [23:0] conv_result;
	logic [1:0] conversion_counter;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [15:0] rv;

	shunt_adc_a_config dut_u (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.standby(standby),
		.power_down(power_down),
		.start_request(start_request),
		.mod_tick(mod_tick),
		.conv_valid(conv_valid),
		.conv_data(conv_data),
		.timing_cfg(timing_cfg),
		.input_cfg(input_cfg),
		.analog_ctrl(analog_ctrl),
		.oversample_ratio(oversample_ratio),
		.modulator_run(modulator_run),
		.data_rate_strobe(data_rate_strobe),
		.conv_result(conv_result),
		.conversion_counter(conversion_counter)
	);

	always #2.5 clk = ~clk;

	// ----------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			$display("MISMATCH at %0t: run did not finish in time", $time);
			test_done;
		end
	end

	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Each bus task lets one edge pass first, so a strobe is never lowered and raised
	// in the same time step when two transfers follow each other.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		tick;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick;
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		tick;
		reg_addr = a;
		reg_rd = 1'b1;
		tick;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd

	task automatic conv(input logic [23:0] d);
		tick;
		conv_data = d;
		conv_valid = 1'b1;
		tick;
		conv_valid = 1'b0;
	endtask : conv

	task automatic wait_run(input logic exp);
		for (int i = 0; i < 8 && modulator_run !== exp; i++) begin
			tick;
		end
		check(24'(modulator_run), 24'(exp), "modulator_run");
	endtask : wait_run

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic test_reset;
		check(24'(oversample_ratio), 24'h000400, "reset ratio");
		rd(`SAC_TIMING_OFFSET, rv);
		check(24'(rv), 24'h000400, "timing reset");
		rd(`SAC_INPUT_OFFSET, rv);
		check(24'(rv), 24'h008010, "input reset");
		check(24'(input_cfg.openwire_sink_route), 24'h000001, "sink route reset");
		rd(8'h84, rv);
		check(24'(rv), 24'h000000, "unmapped read");
		$display("test_reset done");
	endtask : test_reset

	task automatic test_timing;
		wr(`SAC_TIMING_OFFSET, 16'hffff);
		rd(`SAC_TIMING_OFFSET, rv);
		check(24'(rv), 24'h000f0f, "timing reserved");
		wr(`SAC_TIMING_OFFSET, 16'h0005);
		rd(`SAC_TIMING_OFFSET, rv);
		check(24'(rv), 24'h000005, "chop delay");
		check(24'(timing_cfg.global_chop_delay), 24'h000005, "chop delay field");
		check(24'(timing_cfg.global_chop_enable), 24'h000000, "chop off");
		for (int c = 0; c < 8; c++) begin
			wr(`SAC_TIMING_OFFSET, 16'((c << 8) | ((c & 1) << 11) | 8'h08));
			check(24'(oversample_ratio), 24'(14'h0040 << c), "ratio");
			check(24'(timing_cfg.single_shot_select), 24'(c & 1), "mode bit");
			check(24'(timing_cfg.global_chop_enable), 24'h000001, "chop on");
		end
		ce = 1'b0;
		wr(`SAC_TIMING_OFFSET, 16'h0000);
		ce = 1'b1;
		check(24'(oversample_ratio), 24'h002000, "write while frozen");
		wr(`SAC_TIMING_OFFSET, 16'h0400);
		$display("test_timing done");
	endtask : test_timing

	task automatic test_input;
		logic [1:0] l;
		logic [1:0] s_exp;
		logic [1:0] k_exp;
		wr(`SAC_INPUT_OFFSET, 16'hffff);
		rd(`SAC_INPUT_OFFSET, rv);
		check(24'(rv), 24'h008f3f, "input reserved");
		for (int g = 0; g < 4; g++) begin
			wr(`SAC_INPUT_OFFSET, 16'(16'h8000 | (g << 10)));
			tick;
			check(24'(analog_ctrl.analog_gain_x8), 24'(g != 0), "analog gain");
			check(24'(analog_ctrl.digital_shift), 24'((g == 0) ? 0 : g - 1), "shift");
		end
		for (int r = 0; r < 4; r++) begin
			wr(`SAC_INPUT_OFFSET, 16'(16'h8000 | (r << 8)));
			tick;
			check(24'({analog_ctrl.pos_to_ainp, analog_ctrl.neg_to_ainp,
				analog_ctrl.ground_short, analog_ctrl.test_dac_select}),
				24'(4'h8 >> r), "input route");
		end
		for (int i = 0; i < 16; i++) begin
			l = 2'(i >> 2);
			wr(`SAC_INPUT_OFFSET, 16'(16'h8000 | ((i & 1) << 5) | ((i & 2) << 3) | (l << 2) | l));
			tick;
			s_exp = (l == 2'h0) ? 2'h0 : (((i & 1) != 0) ? 2'h1 : 2'h2);
			k_exp = (l == 2'h0) ? 2'h0 : (((i & 2) != 0) ? 2'h1 : 2'h2);
			check(24'({analog_ctrl.source_on_pos, analog_ctrl.source_on_neg}), 24'(s_exp),
				"source pin");
			check(24'({analog_ctrl.sink_on_pos, analog_ctrl.sink_on_neg}), 24'(k_exp),
				"sink pin");
			check(24'(analog_ctrl.source_level), 24'(l), "source level");
			check(24'(analog_ctrl.sink_level), 24'(l), "sink level");
		end
		wr(`SAC_INPUT_OFFSET, 16'h8010);
		$display("test_input done");
	endtask : test_input

	task automatic test_continuous;
		wait_run(1'b1);
		for (int j = 1; j < 6; j++) begin
			conv(24'(24'h100000 + j));
			check(conv_result, 24'(24'h100000 + j), "result");
		end
		// Each pass clears the channel by a different path, then brings it back.
		for (int k = 0; k < 3; k++) begin
			conv(24'habcdef);
			if (k == 0) begin
				standby = 1'b1;
			end else if (k == 1) begin
				power_down = 1'b1;
			end else begin
				wr(`SAC_INPUT_OFFSET, 16'h0010);
			end
			tick;
			tick;
			check(conv_result, 24'h000000, "cleared result");
			check(24'(conversion_counter), 24'h000000, "cleared counter");
			wait_run(1'b0);
			conv(24'h111111);
			check(conv_result, 24'h000000, "idle conversion");
			standby = 1'b0;
			power_down = 1'b0;
			wr(`SAC_INPUT_OFFSET, 16'h8010);
			wait_run(1'b1);
		end
		for (int j = 1; j < 6; j++) begin
			conv(24'h222222);
			check(24'(conversion_counter), 24'(j & 3), "counter wrap");
		end
		$display("test_continuous done");
	endtask : test_continuous

	task automatic test_single;
		int n;
		for (int c = 0; c < 2; c++) begin
			wr(`SAC_TIMING_OFFSET, 16'(16'h0800 | (c << 8)));
			standby = 1'b1;
			tick;
			standby = 1'b0;
			repeat (3) tick;
			check(24'(modulator_run), 24'h000000, "single idle");
			start_request = 1'b1;
			tick;
			start_request = 1'b0;
			wait_run(1'b1);
			mod_tick = 1'b1;
			n = 0;
			while (n < 300 && data_rate_strobe !== 1'b1) begin
				tick;
				n++;
			end
			mod_tick = 1'b0;
			check(24'(n), 24'(64 << c), "rate period");
			conv(24'h5a5a5a);
			check(conv_result, 24'h5a5a5a, "single result");
			wait_run(1'b0);
			start_request = 1'b1;
			tick;
			start_request = 1'b0;
			wait_run(1'b1);
		end
		$display("test_single done");
	endtask : test_single

	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		test_reset;
		test_timing;
		test_input;
		test_continuous;
		test_single;
		test_done;
	end
endmodule : shunt_adc_a_config_tb

`default_nettype wire
